//--- design/ctpwm_map.svh
`ifndef CTPWM_MAP_SVH
`define CTPWM_MAP_SVH
// register byte addresses
`define CTPWM_ADDR_CTRL0     12'h000
`define CTPWM_ADDR_CTRL1     12'h004
`define CTPWM_ADDR_CNT_LO    12'h008
`define CTPWM_ADDR_CNT_HI    12'h00C
`define CTPWM_ADDR_CMPA_LO   12'h010
`define CTPWM_ADDR_CMPA_HI   12'h014
`define CTPWM_ADDR_FLAGS     12'h018
// control zero fields
`define CTPWM_C0_PAUSE       7
`define CTPWM_C0_CKSEL_HI    6
`define CTPWM_C0_CKSEL_LO    4
`define CTPWM_C0_ON          3
`define CTPWM_C0_PER_HI      2
`define CTPWM_C0_PER_LO      0
// control one fields
`define CTPWM_C1_MODE_HI     7
`define CTPWM_C1_MODE_LO     6
`define CTPWM_C1_OFN_HI      5
`define CTPWM_C1_OFN_LO      4
`define CTPWM_C1_INIT        3
`define CTPWM_C1_POL         2
`define CTPWM_C1_SWAP        1
`define CTPWM_C1_CLRSEL      0
// flag register fields, write one to clear
`define CTPWM_FL_A           0
`define CTPWM_FL_P           1
`define CTPWM_CTRL_RESET     8'h00
// clock divider ratios
`define CTPWM_DIV_SYS4       4
`define CTPWM_DIV_H16        16
`define CTPWM_DIV_H64        64
`endif

//--- design/ctpwm_pkg.sv
package ctpwm_pkg;
	typedef enum logic [1:0] {
		CTPWM_MODE_CMP   = 2'h0,
		CTPWM_MODE_UNDEF = 2'h1,
		CTPWM_MODE_PWM   = 2'h2,
		CTPWM_MODE_TMR   = 2'h3
	} ctpwm_mode_e;
	typedef enum logic [1:0] {
		CTPWM_PH_IDLE,
		CTPWM_PH_WRITE,
		CTPWM_PH_READ
	} ctpwm_phase_e;
endpackage : ctpwm_pkg

//--- design/ctpwm_top.sv
`include "ctpwm_map.svh"
`timescale 1ns/10ps
`default_nettype none
module ctpwm_top #(
	parameter int CNT_W = 10
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [11:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        high_clock_tick,
	input  wire logic        sub_clock_tick,
	input  wire logic        external_count_clock_pin,
	output logic             timer_output_pin,
	output logic             timer_output_inverse_pin,
	output logic             timer_output_enable,
	output logic             compare_a_request_flag,
	output logic             compare_p_request_flag
);

////////////////////////////////////////////////////////////////////////////////
// bus slave

	logic [7:0]  ctrl0_r;
	logic [7:0]  ctrl1_r;
	logic [CNT_W-1:0] count_r;
	logic [CNT_W-1:0] cmpa_r;
	logic [7:0]  lo_buf_r;
	logic [11:0] addr_r;
	ctpwm_pkg::ctpwm_phase_e phase_r;
	logic        flag_a_r;
	logic        flag_p_r;
	logic [31:0] hrdata_r;

	wire logic take = hsel & hready & htrans[1];
	wire logic wr_c0 = (phase_r == ctpwm_pkg::CTPWM_PH_WRITE)
		& (addr_r == `CTPWM_ADDR_CTRL0);
	wire logic wr_c1 = (phase_r == ctpwm_pkg::CTPWM_PH_WRITE)
		& (addr_r == `CTPWM_ADDR_CTRL1);
	wire logic wr_alo = (phase_r == ctpwm_pkg::CTPWM_PH_WRITE)
		& (addr_r == `CTPWM_ADDR_CMPA_LO);
	wire logic wr_ahi = (phase_r == ctpwm_pkg::CTPWM_PH_WRITE)
		& (addr_r == `CTPWM_ADDR_CMPA_HI);
	wire logic wr_fl = (phase_r == ctpwm_pkg::CTPWM_PH_WRITE)
		& (addr_r == `CTPWM_ADDR_FLAGS);
	wire logic rd_now = take & ~hwrite;
	wire logic rd_chi = rd_now & (haddr == `CTPWM_ADDR_CNT_HI);
	wire logic rd_ahi = rd_now & (haddr == `CTPWM_ADDR_CMPA_HI);

	logic [31:0] rd_val;
	always_comb begin
		rd_val = 32'h0000_0000;
		if (haddr == `CTPWM_ADDR_CTRL0) begin
			rd_val = {24'h00_0000, ctrl0_r};
		end else if (haddr == `CTPWM_ADDR_CTRL1) begin
			rd_val = {24'h00_0000, ctrl1_r};
		end else if (haddr == `CTPWM_ADDR_CNT_LO
			|| haddr == `CTPWM_ADDR_CMPA_LO) begin
			rd_val = {24'h00_0000, lo_buf_r};
		end else if (haddr == `CTPWM_ADDR_CNT_HI) begin
			rd_val = {30'h0000_0000, count_r[9:8]};
		end else if (haddr == `CTPWM_ADDR_CMPA_HI) begin
			rd_val = {30'h0000_0000, cmpa_r[9:8]};
		end else if (haddr == `CTPWM_ADDR_FLAGS) begin
			rd_val = {30'h0000_0000, flag_p_r, flag_a_r};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_r  <= ctpwm_pkg::CTPWM_PH_IDLE;
			addr_r   <= 12'h000;
			hrdata_r <= 32'h0000_0000;
		end else begin
			phase_r <= !take ? ctpwm_pkg::CTPWM_PH_IDLE :
				hwrite ? ctpwm_pkg::CTPWM_PH_WRITE :
				ctpwm_pkg::CTPWM_PH_READ;
			addr_r <= haddr;
			if (rd_now) begin
				hrdata_r <= rd_val;
			end
		end
	end

////////////////////////////////////////////////////////////////////////////////
// bus answer

	logic hreadyout_r;
	logic hresp_r;

	// zero wait states, always OKAY, both from flops
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout_r <= 1'b1;
			hresp_r     <= 1'b0;
		end else begin
			hreadyout_r <= 1'b1;
			hresp_r     <= 1'b0;
		end
	end

	assign hrdata    = hrdata_r;
	assign hreadyout = hreadyout_r;
	assign hresp     = hresp_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lo_buf_r <= 8'h00;
		end else if (wr_alo) begin
			lo_buf_r <= hwdata[7:0];
		end else if (rd_chi) begin
			lo_buf_r <= count_r[7:0];
		end else if (rd_ahi) begin
			lo_buf_r <= cmpa_r[7:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmpa_r <= 10'h000;
		end else if (wr_ahi) begin
			cmpa_r <= {hwdata[1:0], lo_buf_r};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl0_r <= `CTPWM_CTRL_RESET;
			ctrl1_r <= `CTPWM_CTRL_RESET;
		end else begin
			if (wr_c0) begin
				ctrl0_r <= hwdata[7:0];
			end
			if (wr_c1) begin
				ctrl1_r <= hwdata[7:0];
			end
		end
	end

////////////////////////////////////////////////////////////////////////////////
// count clock

	wire logic       pause   = ctrl0_r[`CTPWM_C0_PAUSE];
	wire logic [2:0] cksel   = ctrl0_r[`CTPWM_C0_CKSEL_HI:`CTPWM_C0_CKSEL_LO];
	wire logic       on      = ctrl0_r[`CTPWM_C0_ON];
	wire logic [2:0] per     = ctrl0_r[`CTPWM_C0_PER_HI:`CTPWM_C0_PER_LO];
	wire logic [1:0] mode    = ctrl1_r[`CTPWM_C1_MODE_HI:`CTPWM_C1_MODE_LO];
	wire logic [1:0] ofn     = ctrl1_r[`CTPWM_C1_OFN_HI:`CTPWM_C1_OFN_LO];
	wire logic       init    = ctrl1_r[`CTPWM_C1_INIT];
	wire logic       pol     = ctrl1_r[`CTPWM_C1_POL];
	wire logic       swap    = ctrl1_r[`CTPWM_C1_SWAP];
	wire logic       clrsel  = ctrl1_r[`CTPWM_C1_CLRSEL];
	// mode decode, 01 acts as timer
	wire logic       is_pwm  = (mode == ctpwm_pkg::CTPWM_MODE_PWM);
	wire logic       is_cmp  = (mode == ctpwm_pkg::CTPWM_MODE_CMP);
	wire logic       is_tmr  = ~is_pwm & ~is_cmp;

	logic [1:0] sys_div_r;
	logic [5:0] h_div_r;
	logic       ext_d_r;
	logic       on_d_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sys_div_r <= 2'h0;
			h_div_r   <= 6'h00;
			ext_d_r   <= 1'b0;
			on_d_r    <= 1'b0;
		end else begin
			sys_div_r <= sys_div_r + 2'h1;
			if (high_clock_tick) begin
				h_div_r <= h_div_r + 6'h01;
			end
			ext_d_r <= external_count_clock_pin;
			on_d_r  <= on;
		end
	end

	wire logic sys4_tick = (sys_div_r == 2'(`CTPWM_DIV_SYS4 - 1));
	wire logic h16_tick  = high_clock_tick
		& (h_div_r[3:0] == 4'(`CTPWM_DIV_H16 - 1));
	wire logic h64_tick  = high_clock_tick
		& (h_div_r == 6'(`CTPWM_DIV_H64 - 1));
	wire logic ext_rise  = external_count_clock_pin & ~ext_d_r;
	wire logic ext_fall  = ~external_count_clock_pin & ext_d_r;
	wire logic on_rise   = on & ~on_d_r;

	logic src_tick;
	always_comb begin
		case (cksel)
			3'h0:    src_tick = sys4_tick;
			3'h1:    src_tick = 1'b1;
			3'h2:    src_tick = h16_tick;
			3'h3:    src_tick = h64_tick;
			3'h6:    src_tick = ext_rise;
			3'h7:    src_tick = ext_fall;
			default: src_tick = sub_clock_tick;
		endcase
	end

	wire logic tick = src_tick & on & ~pause;

////////////////////////////////////////////////////////////////////////////////
// comparators and counter

	wire logic [CNT_W-1:0] next_cnt = count_r + 10'h001;
	wire logic match_p = tick & (per != 3'h0) & (next_cnt[9:7] == per)
		& (next_cnt[6:0] == 7'h00);
	wire logic match_a = tick & (cmpa_r != 10'h000) & (next_cnt == cmpa_r);
	wire logic ovf     = tick & (count_r == 10'h3FF);
	// code zero period is full range
	wire logic p_event = match_p | (ovf & (per == 3'h0));

	wire logic pwm_per = swap ? match_a : p_event;
	wire logic pwm_dut = swap ? p_event : match_a;
	// clear on P; clear on A, ignored in PWM
	wire logic clr_evt = is_pwm ? pwm_per : (clrsel ? match_a : p_event);
	// P flag absent when A clears, outside PWM
	wire logic set_p = p_event & (is_pwm | ~clrsel);
	wire logic set_a = match_a;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_r <= 10'h000;
		// clear on timer on rising edge
		end else if (on_rise) begin
			count_r <= 10'h000;
		end else if (clr_evt | ovf) begin
			count_r <= 10'h000;
		end else if (tick) begin
			count_r <= next_cnt;
		end
	end

////////////////////////////////////////////////////////////////////////////////
// request flags

	wire logic clr_a = wr_fl & hwdata[`CTPWM_FL_A];
	wire logic clr_p = wr_fl & hwdata[`CTPWM_FL_P];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flag_a_r <= 1'b0;
			flag_p_r <= 1'b0;
		end else begin
			flag_a_r <= set_a | (flag_a_r & ~clr_a);
			flag_p_r <= set_p | (flag_p_r & ~clr_p);
		end
	end

	assign compare_a_request_flag = flag_a_r;
	assign compare_p_request_flag = flag_p_r;

////////////////////////////////////////////////////////////////////////////////
// output pins

	logic cmp_lvl_r;
	logic pwm_act_r;
	logic pin_r;
	logic pin_n_r;
	logic pin_en_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmp_lvl_r <= 1'b0;
			pwm_act_r <= 1'b0;
		end else if (on_rise) begin
			cmp_lvl_r <= init;
			pwm_act_r <= 1'b1;
		end else begin
			// match action; same level no change
			if (match_a & is_cmp) begin
				case (ofn)
					2'h1:    cmp_lvl_r <= 1'b0;
					2'h2:    cmp_lvl_r <= 1'b1;
					2'h3:    cmp_lvl_r <= ~cmp_lvl_r;
					default: cmp_lvl_r <= cmp_lvl_r;
				endcase
			end
			if (is_pwm & pwm_per) begin
				pwm_act_r <= 1'b1;
			end else if (is_pwm & pwm_dut) begin
				pwm_act_r <= 1'b0;
			end
		end
	end

	logic pwm_state;
	always_comb begin
		case (ofn)
			2'h0:    pwm_state = 1'b0;
			2'h1:    pwm_state = 1'b1;
			default: pwm_state = pwm_act_r;
		endcase
	end

	wire logic pwm_lvl = init ? pwm_state : ~pwm_state;
	wire logic pin_nxt = (is_pwm ? pwm_lvl : cmp_lvl_r) ^ pol;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_r   <= 1'b0;
			pin_n_r <= 1'b1;
		end else begin
			pin_r   <= pin_nxt;
			pin_n_r <= ~pin_nxt;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_en_r <= 1'b0;
		end else begin
			pin_en_r <= ~is_tmr;
		end
	end

	assign timer_output_pin         = pin_r;
	assign timer_output_inverse_pin = pin_n_r;
	assign timer_output_enable      = pin_en_r;

endmodule : ctpwm_top
`default_nettype wire

//--- test/compact_timer_pwm_unit_tb.sv
`timescale 1ns/10ps
`default_nettype none
module compact_timer_pwm_unit_tb;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [11:0] haddr = 12'h000;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic        go = 1'b0;
	logic [31:0] hrdata, v, w;
	logic        hreadyout, hresp, pin, npin, oe, fa, fp, busy, ext;
	wire  [3:0]  sv;
	int          n_mismatch = 0;
	int          checked = 0;
	int          n;
	assign sv = {~busy, fp, fa, hreadyout};
	ctpwm_top dut (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
		.high_clock_tick(1'b0), .sub_clock_tick(1'b0),
		.external_count_clock_pin(ext), .timer_output_pin(pin),
		.timer_output_inverse_pin(npin), .timer_output_enable(oe),
		.compare_a_request_flag(fa), .compare_p_request_flag(fp)
	);
	ctpwm_far far (.hclk, .go, .busy, .ext_pin(ext));
	initial begin
		forever #50 hclk = ~hclk;
	end
	////////////////////////////////////////////////////////////////
	task close_out;
		$display("mismatches %0d checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : close_out
	task cmp(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask : cmp
	task cb(input logic g, input logic e);
		cmp({31'h0, g}, {31'h0, e});
	endtask : cb
	task automatic wt(input int k, output int c);
		for (c = 0; c < 2000; c++) begin
			@(posedge hclk);
			if (sv[k] === 1'b1)
				return;
		end
		n_mismatch++;
		$display("[ERR] %0t wait timeout", $time);
		close_out();
	endtask : wt
	task automatic xfer(input logic wr, input logic [11:0] a,
		input logic [7:0] d, output logic [31:0] q);
		int k;
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		wt(0, k);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		wt(0, k);
		q = hrdata;
	endtask : xfer
	task wr(input logic [11:0] a, input logic [7:0] d);
		xfer(1'b1, a, d, w);
	endtask : wr
	task rdc(input logic [11:0] a, input logic [31:0] e);
		xfer(1'b0, a, 8'h00, w);
		cmp(w, e);
	endtask : rdc
	task cnt(output logic [31:0] c);
		xfer(1'b0, 12'h00C, 8'h00, c);
		xfer(1'b0, 12'h008, 8'h00, w);
		c = {22'h0, c[1:0], w[7:0]};
	endtask : cnt
	////////////////////////////////////////////////////////////////
	task s_regs;
		cb(npin, 1'b1);
		rdc(12'h000, 32'h0);
		rdc(12'h004, 32'h0);
		rdc(12'h01C, 32'h0);
		wr(12'h010, 8'hC8);
		wr(12'h014, 8'h01);
		rdc(12'h014, 32'h1);
		rdc(12'h010, 32'hC8);
	endtask : s_regs
	task s_count;
		wr(12'h00C, 8'h03);
		cnt(v);
		cmp(v, 32'h0);
		wr(12'h000, 8'h18);
		repeat (20) @(posedge hclk);
		wr(12'h000, 8'h10);
		cnt(v);
		repeat (9) @(posedge hclk);
		cnt(w);
		cmp(w, v);
		wr(12'h000, 8'h98);
		cnt(v);
		cmp(v, 32'h0);
		wr(12'h000, 8'h18);
		repeat (5) @(posedge hclk);
		wr(12'h000, 8'h98);
		cnt(v);
		cb(v !== 32'h0, 1'b1);
		repeat (9) @(posedge hclk);
		cnt(w);
		cmp(w, v);
	endtask : s_count
	task s_ext;
		for (int k = 6; k < 8; k++) begin
			wr(12'h000, 8'h00);
			wr(12'h000, {1'b0, k[2:0], 4'h8});
			go <= 1'b1;
			@(posedge hclk);
			go <= 1'b0;
			repeat (2) @(posedge hclk);
			wt(3, n);
			repeat (4) @(posedge hclk);
			cnt(v);
			cmp(v, 32'h5);
		end
	endtask : s_ext
	task s_cmp;
		for (int f = 0; f < 4; f++) begin
			wr(12'h000, 8'h10);
			wr(12'h004, {2'h0, f[1:0], 4'h1});
			wr(12'h018, 8'h03);
			wr(12'h000, 8'h18);
			repeat (3) @(posedge hclk);
			cb(pin, 1'b0);
			wt(1, n);
			repeat (3) @(posedge hclk);
			cb(pin, f[1]);
			cb(fp, 1'b0);
		end
		wr(12'h018, 8'h01);
		repeat (2) @(posedge hclk);
		cb(fa, 1'b0);
	endtask : s_cmp
	task s_per;
		for (int p = 1; p >= 0; p--) begin
			wr(12'h000, 8'h10);
			wr(12'h004, 8'hC0);
			wr(12'h018, 8'h03);
			wr(12'h000, {5'h03, p[2:0]});
			wt(2, n);
			cb(n >= (p ? 125 : 1021) && n <= (p ? 133 : 1029), 1'b1);
			cb(oe, 1'b0);
		end
		wr(12'h000, 8'h10);
		wr(12'h004, 8'hA0);
		wr(12'h018, 8'h03);
		wr(12'h000, 8'h18);
		repeat (8) @(posedge hclk);
		cb(oe, 1'b1);
		cb(pin, 1'b0);
		wt(1, n);
		repeat (3) @(posedge hclk);
		cb(pin, 1'b1);
	endtask : s_per
	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		s_regs();
		s_count();
		s_ext();
		s_cmp();
		s_per();
		close_out();
	end
endmodule : compact_timer_pwm_unit_tb
`default_nettype wire

//--- test/ctpwm_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module ctpwm_asserts #(
	parameter int CNT_W = 10
) (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        timer_output_pin,
	input wire logic        timer_output_inverse_pin,
	input wire logic        timer_output_enable,
	input wire logic        compare_a_request_flag,
	input wire logic        compare_p_request_flag
);
	logic       take;
	logic       fl_r;
	logic       c1_r;
	logic [1:0] mode_r;
	assign take = hsel & hready & htrans[1];
	// mirror of the mode field from bus writes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fl_r <= 1'b0;
			c1_r <= 1'b0;
			mode_r <= 2'h0;
		end else begin
			fl_r <= take & hwrite & (haddr == 12'h018);
			c1_r <= take & hwrite & (haddr == 12'h004);
			if (c1_r)
				mode_r <= hwdata[7:6];
		end
	end
	default clocking dc @(posedge hclk); endclocking
	default disable iff (!hresetn);
	inv_pin_a: assert property (
		timer_output_inverse_pin == !timer_output_pin) else $error("inverse");
	bus_ok_a: assert property (
		hreadyout && !hresp) else $error("bus answer");
	rd_hold_a: assert property (
		$changed(hrdata) |-> $past(take && !hwrite)) else $error("rdata");
	clr_fa_a: assert property (
		$fell(compare_a_request_flag) |-> $past(fl_r & hwdata[0]))
		else $error("flag a lost");
	clr_fp_a: assert property (
		$fell(compare_p_request_flag) |-> $past(fl_r & hwdata[1]))
		else $error("flag p lost");
	tmr_oe_a: assert property (
		(mode_r == 2'h3) [*4] |-> !timer_output_enable) else $error("oe tmr");
	cmp_oe_a: assert property (
		(mode_r == 2'h0) [*4] |-> timer_output_enable) else $error("oe cmp");
	pwm_oe_a: assert property (
		(mode_r == 2'h2) [*4] |-> timer_output_enable) else $error("oe pwm");
	cover property ($rose(compare_a_request_flag));
	cover property ($rose(compare_p_request_flag));
	cover property ($rose(timer_output_pin));
endmodule : ctpwm_asserts
bind ctpwm_top ctpwm_asserts #(.CNT_W(CNT_W)) u_chk (
	.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata,
	.hrdata, .hreadyout, .hresp, .timer_output_pin,
	.timer_output_inverse_pin, .timer_output_enable,
	.compare_a_request_flag, .compare_p_request_flag
);
`default_nettype wire

//--- test/ctpwm_far.sv
`timescale 1ns/10ps
`default_nettype none
module ctpwm_far (
	input  wire logic hclk,
	input  wire logic go,
	output var  logic busy,
	output var  logic ext_pin
);
	// idles low, five full pulses per request
	initial begin
		busy = 1'b0;
		ext_pin = 1'b0;
		forever begin
			@(posedge hclk);
			if (go) begin
				busy <= 1'b1;
				repeat (10) begin
					repeat (4) @(posedge hclk);
					ext_pin <= ~ext_pin;
				end
				busy <= 1'b0;
			end
		end
	end
endmodule : ctpwm_far
`default_nettype wire
